/* File: hdl/sbi_params.svh */
`ifndef SBI_PARAMS_SVH
`define SBI_PARAMS_SVH

// hardware reset entry: ticks of the slower clock
`define SBI_RESET_TICKS   4'd10
`define SBI_RESET_LAST    4'd9
`define SBI_CNT_ZERO      4'h0
`define SBI_CNT_ONE       4'h1

// bus cycle status codes
`define SBI_STAT_IDLE     3'h0
`define SBI_STAT_DMA_RD   3'h1
`define SBI_STAT_DMA_WR   3'h2
`define SBI_STAT_REQUEST  3'h3
`define SBI_STAT_SLAVE    3'h4
`define SBI_STAT_MEMORY   3'h5
`define SBI_STAT_RESET    3'h7

// data bus lane split and idle values
`define SBI_HALF_ZERO     16'h0000
`define SBI_WORD_ZERO     32'h0000_0000
`define SBI_ADDR_ZERO     31'h0000_0000
`define SBI_INDEX_ZERO    6'h00

`endif

/* File: hdl/sbi_pkg.sv */
package sbi_pkg;

  // one dma transfer request from the engine core
  typedef struct packed {
    logic        valid;  // request pending
    logic        write;  // 1 = write to memory
    logic        wide;   // 1 = 32-bit, 0 = 16-bit
    logic [30:0] addr;   // word address
    logic [31:0] data;   // write data, natural order
  } sbi_dma_req_t;

  // bus interface sequencer states
  typedef enum logic [2:0] {
    SBI_IDLE,
    SBI_REQ,
    SBI_ADDR,
    SBI_DATA,
    SBI_SLAVE,
    SBI_MEM
  } sbi_state_t;

endpackage : sbi_pkg

/* File: hdl/sbi_bus_pins.sv */
`timescale 1ns/1ps
// Functional notes
// - order select high big endian, low little
// - order select also picks control protocol family
// - master: 16-bit low lanes, 32-bit all lanes
// - slave reads drive low half, upper floats
// - dma address driven only after bus granted
// - reset after ten transmit or bus clocks
// - status output always shows current bus cycle
// - dma timing runs on the bus clock
// - acknowledge low on chip select with index strobe, or on memory request
`include "sbi_params.svh"

module sbi_bus_pins (
  input  wire logic                 ref_clk,          // bus clock
  input  wire logic                 rst,
  input  wire logic                 byteOrderSelect,  // 1 = big endian
  input  wire logic                 transmitClock,    // sampled level
  input  wire logic                 busClockSlower,   // bus period longer
  input  wire logic                 hwResetN,         // hardware reset
  input  wire logic                 chipSelectN,
  input  wire logic                 slaveIndexStrobe,
  input  wire logic                 slaveRead,        // 1 = host reads
  input  wire logic [5:0]           registerIndexLines,
  input  wire logic                 sharedMemoryRequestN,
  input  wire logic [31:0]          sysDataIn,
  input  wire logic                 busGrant,
  input  wire sbi_pkg::sbi_dma_req_t dmaReq,
  input  wire logic [15:0]          regReadData,
  output logic [31:0]               sysDataOut,
  output logic                      sysDataOeLo,
  output logic                      sysDataOeHi,
  output logic [30:0]               masterWordAddressLines,
  output logic                      masterAddrOe,
  output logic                      busRequest,
  output logic [2:0]                busCycleStatus,
  output logic                      slaveMemoryAckN,
  output logic                      protocolFamily,
  output logic                      bigEndian,
  output logic                      deviceInReset,
  output logic [5:0]                regIndex,
  output logic                      regAccess,
  output logic                      regWrite,
  output logic [15:0]               regWriteData,
  output logic                      dmaDone,
  output logic [31:0]               dmaReadData
);
  import sbi_pkg::*;

  sbi_state_t   state_q;     // sequencer state
  sbi_dma_req_t req_q;       // latched dma request
  logic         txPrev_q;    // last transmit clock level
  logic [3:0]   rstCnt_q;    // reset entry tick counter
  logic         txRise;      // transmit clock rising edge
  logic         rstTick;     // one tick of the slower clock
  wire  [31:0]  wrSwap;      // write data in bus order
  wire  [31:0]  rdSwap;      // read data in natural order

  assign txRise  = transmitClock & ~txPrev_q;
  assign rstTick = busClockSlower | txRise;

  // byte lane steering per lane for both directions
  // little: straight; big wide: reverse four; big narrow: swap pairs
  genvar i;
  for (i = 0; i < 4; i++) begin : g_lane
    assign wrSwap[8*i +: 8] = !bigEndian ? req_q.data[8*i +: 8] :
                              req_q.wide ? req_q.data[8*(3-i) +: 8] :
                                           req_q.data[8*(i^1) +: 8];
    assign rdSwap[8*i +: 8] = !bigEndian ? sysDataIn[8*i +: 8] :
                              req_q.wide ? sysDataIn[8*(3-i) +: 8] :
                                           sysDataIn[8*(i^1) +: 8];
  end

  // mode pins: byte order and control family
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bigEndian      <= 1'b0;
      protocolFamily <= 1'b0;
    end else begin
      bigEndian      <= byteOrderSelect;
      protocolFamily <= byteOrderSelect;
    end
  end

  // hardware reset entry after ten ticks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txPrev_q      <= transmitClock;  // no false edge after reset
      rstCnt_q      <= `SBI_CNT_ZERO;
      deviceInReset <= 1'b0;
    end else begin
      txPrev_q <= transmitClock;
      if (hwResetN) begin
        // released: leave reset at once
        rstCnt_q      <= `SBI_CNT_ZERO;
        deviceInReset <= 1'b0;
      end else if (!deviceInReset && rstTick) begin
        if (rstCnt_q == `SBI_RESET_LAST) begin
          deviceInReset <= 1'b1;
        end
        rstCnt_q <= rstCnt_q + `SBI_CNT_ONE;
      end
    end
  end

  // sequencer: slave, shared memory and dma master
  always_ff @(posedge ref_clk) begin
    if (rst || deviceInReset) begin
      state_q <= SBI_IDLE;
      req_q   <= '0;
    end else begin
      case (state_q)
        SBI_IDLE: begin
          // host accesses win over the dma engine
          if (!chipSelectN && slaveIndexStrobe) begin
            state_q <= SBI_SLAVE;
          end else if (!sharedMemoryRequestN) begin
            state_q <= SBI_MEM;
          end else if (dmaReq.valid) begin
            req_q   <= dmaReq;
            state_q <= SBI_REQ;
          end
        end
        SBI_REQ:   if (busGrant) state_q <= SBI_ADDR;
        SBI_ADDR:  state_q <= SBI_DATA;
        SBI_DATA:  state_q <= SBI_IDLE;
        // host access ends when its select is released
        SBI_SLAVE: if (chipSelectN) state_q <= SBI_IDLE;
        SBI_MEM:   if (sharedMemoryRequestN) state_q <= SBI_IDLE;
        default: state_q <= SBI_IDLE;
      endcase
    end
  end

  // master address, request and data lanes
  always_ff @(posedge ref_clk) begin
    if (rst || deviceInReset) begin
      busRequest             <= 1'b0;
      masterAddrOe           <= 1'b0;
      masterWordAddressLines <= `SBI_ADDR_ZERO;
      sysDataOut             <= `SBI_WORD_ZERO;
      sysDataOeLo            <= 1'b0;
      sysDataOeHi            <= 1'b0;
      dmaDone                <= 1'b0;
      dmaReadData            <= `SBI_WORD_ZERO;
    end else begin
      dmaDone <= 1'b0;
      case (state_q)
        SBI_REQ: begin
          busRequest <= ~busGrant;
          if (busGrant) begin
            // address only once the bus is ours
            masterAddrOe           <= 1'b1;
            masterWordAddressLines <= req_q.addr;
            sysDataOut             <= wrSwap;
            sysDataOeLo            <= req_q.write;
            sysDataOeHi            <= req_q.write & req_q.wide;
          end
        end
        SBI_ADDR: begin
          // read data lands this cycle
          if (!req_q.write) begin
            dmaReadData <= req_q.wide ? rdSwap :
                           {`SBI_HALF_ZERO, rdSwap[15:0]};
          end
        end
        SBI_DATA: begin
          masterAddrOe <= 1'b0;
          sysDataOeLo  <= 1'b0;
          sysDataOeHi  <= 1'b0;
          dmaDone      <= 1'b1;
        end
        SBI_SLAVE: begin
          // register data on the low half only
          sysDataOut  <= {`SBI_HALF_ZERO, regReadData};
          sysDataOeLo <= slaveRead & ~chipSelectN;
          sysDataOeHi <= 1'b0;
        end
        default: begin
          // idle and memory cycles: master side released
          busRequest  <= 1'b0;
          sysDataOeLo <= 1'b0;
          sysDataOeHi <= 1'b0;
        end
      endcase
    end
  end

  // slave acknowledge and register index latch
  always_ff @(posedge ref_clk) begin
    if (rst || deviceInReset) begin
      slaveMemoryAckN <= 1'b1;
      regIndex        <= `SBI_INDEX_ZERO;
      regAccess       <= 1'b0;
      regWrite        <= 1'b0;
      regWriteData    <= `SBI_HALF_ZERO;
    end else begin
      regAccess <= 1'b0;
      regWrite  <= 1'b0;
      if (state_q == SBI_IDLE && !chipSelectN && slaveIndexStrobe) begin
        regIndex        <= registerIndexLines;
        regAccess       <= 1'b1;
        slaveMemoryAckN <= 1'b0;
      end else if (state_q == SBI_IDLE && !sharedMemoryRequestN) begin
        slaveMemoryAckN <= 1'b0;
      end else if (state_q == SBI_SLAVE && !chipSelectN) begin
        slaveMemoryAckN <= 1'b0;
        if (!slaveRead && regAccess) begin  // one write per access
          regWrite     <= 1'b1;
          regWriteData <= sysDataIn[15:0];
        end
      end else if (state_q == SBI_MEM && !sharedMemoryRequestN) begin
        slaveMemoryAckN <= 1'b0;
      end else begin
        slaveMemoryAckN <= 1'b1;
      end
    end
  end

  // continuous bus cycle status
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busCycleStatus <= `SBI_STAT_IDLE;
    end else if (deviceInReset) begin
      busCycleStatus <= `SBI_STAT_RESET;
    end else begin
      case (state_q)
        // grant seen: status turns to the cycle with the address
        SBI_REQ:   busCycleStatus <= !busGrant ? `SBI_STAT_REQUEST :
                                     req_q.write ? `SBI_STAT_DMA_WR :
                                                   `SBI_STAT_DMA_RD;
        SBI_ADDR,
        SBI_DATA:  busCycleStatus <= req_q.write ? `SBI_STAT_DMA_WR :
                                                   `SBI_STAT_DMA_RD;
        SBI_SLAVE: busCycleStatus <= `SBI_STAT_SLAVE;
        SBI_MEM:   busCycleStatus <= `SBI_STAT_MEMORY;
        default:   busCycleStatus <= `SBI_STAT_IDLE;
      endcase
    end
  end

  // checks next to the logic
  a_big_lanes: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(masterAddrOe) && sysDataOeHi && bigEndian
    |-> sysDataOut[7:0] == req_q.data[31:24])
    else $error("big endian lane order wrong");
  a_family_follow: assert property (@(posedge ref_clk) disable iff (rst)
    byteOrderSelect ##1 byteOrderSelect |=> protocolFamily)
    else $error("protocol family not following order select");
  a_narrow_hi: assert property (@(posedge ref_clk) disable iff (rst)
    masterAddrOe && !req_q.wide |-> !sysDataOeHi)
    else $error("upper lanes driven on narrow transfer");
  a_slave_upper: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == SBI_SLAVE |=> !sysDataOeHi)
    else $error("upper lanes driven during slave access");
  a_addr_grant: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(masterAddrOe) |-> $past(busGrant) && $past(busRequest))
    else $error("address driven without grant");
  // helper: bus clocks spent in hardware reset on the slow clock
  logic [3:0] slowLow_q;  // saturates at the reset tick count
  always_ff @(posedge ref_clk) begin
    if (rst || hwResetN || !busClockSlower || deviceInReset) begin
      slowLow_q <= `SBI_CNT_ZERO;
    end else if (slowLow_q != `SBI_RESET_TICKS) begin
      slowLow_q <= slowLow_q + `SBI_CNT_ONE;
    end
  end
  a_reset_ten: assert property (@(posedge ref_clk) disable iff (rst)
    slowLow_q == `SBI_RESET_TICKS |-> deviceInReset)
    else $error("reset not entered after ten bus clocks");
  a_reset_early: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(hwResetN) |=> !deviceInReset [*8])
    else $error("reset entered too early");
  a_status_dma: assert property (@(posedge ref_clk) disable iff (rst)
    masterAddrOe && !deviceInReset |-> busCycleStatus == `SBI_STAT_DMA_WR
      || busCycleStatus == `SBI_STAT_DMA_RD)
    else $error("status not showing dma cycle");
  a_dma_timing: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == SBI_REQ && busGrant && !deviceInReset && hwResetN
    ##1 hwResetN ##1 hwResetN |=> dmaDone)
    else $error("dma cycle length wrong");
  a_ack_cs: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == SBI_IDLE && !deviceInReset && hwResetN
    && !chipSelectN && slaveIndexStrobe |=> !slaveMemoryAckN)
    else $error("no acknowledge on chip select");

  c_dma_write: cover property (@(posedge ref_clk)
    state_q == SBI_ADDR && req_q.write);
  c_dma_read: cover property (@(posedge ref_clk) dmaDone && !req_q.write);
  c_slave: cover property (@(posedge ref_clk) regAccess);
  c_memory: cover property (@(posedge ref_clk) state_q == SBI_MEM);
  c_reset: cover property (@(posedge ref_clk) $rose(deviceInReset));

endmodule : sbi_bus_pins

/* File: testbench/sbi_host_model.sv */
`timescale 1ns/1ps
// host side of the bus: arbiter grant and shared memory for dma cycles
module sbi_host_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        busRequest,
  input  wire logic        masterAddrOe,
  input  wire logic        sysDataOeLo,
  input  wire logic [3:0]  grantDelay,
  input  wire logic [31:0] memWord,
  input  wire logic        busDrive,
  input  wire logic [31:0] busWord,
  output logic             busGrant,
  output logic [31:0]      sysDataIn
);
  logic [3:0]  waitCnt_q;  // cycles left before grant
  logic [31:0] junk_q;     // shown on a released bus, changes every cycle

  // grant after a chosen delay, withdrawn once the request falls
  always_ff @(posedge ref_clk) begin
    if (rst || !busRequest) begin
      waitCnt_q <= grantDelay;
      busGrant  <= 1'b0;
    end else if (waitCnt_q != 4'h0) begin
      waitCnt_q <= waitCnt_q - 4'h1;
    end else begin
      busGrant <= 1'b1;
    end
  end

  // floating bus never repeats its last value
  always_ff @(posedge ref_clk) begin
    junk_q <= rst ? 32'h5a5a_a5a5 : ~junk_q;
  end

  // host cpu data for register writes, memory data for dma reads
  assign sysDataIn = busDrive ? busWord :
    (masterAddrOe && !sysDataOeLo) ? memWord : junk_q;
endmodule : sbi_host_model

/* File: testbench/test_sbi_bus_pins.sv */
`timescale 1ns/1ps
// checks the pin-level bus interface against a behavioural model
module test_sbi_bus_pins;
  import sbi_pkg::*;
  logic ref_clk, rst, byteOrderSelect, busClockSlower;
  logic transmitClock = 1'b0;  // free running, toggled below
  logic hwResetN, chipSelectN, slaveIndexStrobe, slaveRead, busGrant;
  logic sharedMemoryRequestN, sysDataOeLo, sysDataOeHi, masterAddrOe;
  logic busRequest, slaveMemoryAckN, protocolFamily, bigEndian;
  logic deviceInReset, regAccess, regWrite, dmaDone, busDrive;
  logic [5:0]   registerIndexLines, regIndex;
  logic [15:0]  regReadData, regWriteData;
  logic [31:0]  sysDataIn, sysDataOut, dmaReadData, memWord, busWord;
  logic [30:0]  masterWordAddressLines;
  logic [2:0]   busCycleStatus;
  logic [3:0]   grantDelay;
  sbi_dma_req_t dmaReq;
  logic [31:0]  seed = 32'h10d2bf15;  // xorshift state
  int           n_errors = 0;
  int           checks = 0;
  int           n;
  logic [31:0]  expQ[$];             // expected dma words

  sbi_bus_pins   i_sbi_bus_pins (.*);
  sbi_host_model i_sbi_host_model (.*);

  // 40 MHz bus clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // transmit clock runs at half the bus rate
  always @(posedge ref_clk) transmitClock <= ~transmitClock;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // byte order model: big endian swaps bytes within the transfer
  function automatic logic [31:0] order(logic [31:0] w, logic big, logic wd);
    if (!big) return w;
    if (wd) return {w[7:0], w[15:8], w[23:16], w[31:24]};
    return {w[31:16], w[7:0], w[15:8]};
  endfunction : order

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // one host register access, then the required idle gap
  task automatic reg_access(logic rd);
    logic [31:0] r;
    r = rnd();
    @(posedge ref_clk);
    chipSelectN <= 1'b0;
    slaveIndexStrobe <= 1'b1;
    slaveRead <= rd;
    registerIndexLines <= r[21:16];
    regReadData <= r[15:0];
    busWord <= r;
    busDrive <= !rd;
    @(posedge ref_clk);
    #1 check("ack", slaveMemoryAckN, 0);
    check("index", regIndex, r[21:16]);
    check("latch", regAccess, 1);
    @(posedge ref_clk);
    #1 check("slave status", busCycleStatus, 3'h4);
    if (rd) begin
      check("oe low", sysDataOeLo, 1);
      check("oe high", sysDataOeHi, 0);
      check("read lanes", sysDataOut[15:0], r[15:0]);
    end else begin
      check("write", {regWrite, regWriteData}, {1'b1, r[15:0]});
    end
    @(posedge ref_clk);
    chipSelectN <= 1'b1;
    slaveIndexStrobe <= 1'b0;
    busDrive <= 1'b0;
    #1 check("write once", regWrite, 0);
    @(posedge ref_clk);
    #1 check("ack off", {slaveMemoryAckN, sysDataOeLo}, 2'b10);
    repeat (3) @(posedge ref_clk);
  endtask : reg_access

  // one dma transfer with a chosen order, width, direction and grant delay
  task automatic dma(logic big, logic wd, logic wr, logic [3:0] dly);
    logic [31:0] a, d, m, mask;
    a = rnd();
    d = rnd();
    m = rnd();
    mask = wd ? 32'hffff_ffff : 32'h0000_ffff;
    expQ.push_back(order(wr ? d : m, big, wd) & mask);
    @(posedge ref_clk);
    byteOrderSelect <= big;
    grantDelay <= dly;
    memWord <= m;
    dmaReq <= '{1'b1, wr, wd, a[30:0], d};
    @(posedge ref_clk);
    #1 check("order", {bigEndian, protocolFamily}, {big, big});
    @(posedge ref_clk);
    #1 check("request", {busRequest, busCycleStatus}, 4'hb);
    check("no addr", masterAddrOe, 0);
    for (n = 0; n < 30 && !masterAddrOe; n++) @(negedge ref_clk);
    check("grant wait", n < 30, 1);
    if (n >= 30) final_report();
    check("addr", masterWordAddressLines, a[30:0]);
    check("dma status", busCycleStatus, wr ? 3'h2 : 3'h1);
    check("lanes", {sysDataOeHi, sysDataOeLo}, {wr & wd, wr});
    if (wr) check("wdata", sysDataOut & mask, expQ[0]);
    @(posedge ref_clk);
    @(posedge ref_clk);
    dmaReq.valid <= 1'b0;
    #1 check("done", dmaDone, 1);
    if (!wr) check("rdata", dmaReadData & mask, expQ[0]);
    void'(expQ.pop_front());
  endtask : dma

  // hardware reset: model counts ticks of the slower clock
  task automatic hw_reset(logic slow);
    int ticks;
    ticks = 0;
    @(posedge ref_clk);
    busClockSlower <= slow;
    hwResetN <= 1'b0;
    for (n = 0; n < 40 && ticks < 10; n++) begin
      @(posedge ref_clk);
      #1 if (slow || !transmitClock) ticks++;
      check("in reset", deviceInReset, ticks == 10);
    end
    @(posedge ref_clk);
    hwResetN <= 1'b1;
    #1 check("reset status", busCycleStatus, 3'h7);
    @(posedge ref_clk);
    #1 check("reset off", deviceInReset, 0);
  endtask : hw_reset

  initial begin
    {rst, hwResetN, chipSelectN, sharedMemoryRequestN} = 4'hf;
    {byteOrderSelect, busClockSlower} = 2'h0;
    {slaveIndexStrobe, slaveRead, busDrive} = 3'h0;
    registerIndexLines = 6'h00;
    regReadData = 16'h0000;
    busWord = 32'h0000_0000;
    memWord = 32'h0000_0000;
    grantDelay = 4'h0;
    dmaReq = '0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 check("idle", {slaveMemoryAckN, busCycleStatus}, 4'h8);
    reg_access(1'b1);
    reg_access(1'b0);
    // shared memory request
    @(posedge ref_clk);
    sharedMemoryRequestN <= 1'b0;
    @(posedge ref_clk);
    #1 check("mem ack", slaveMemoryAckN, 0);
    @(posedge ref_clk);
    sharedMemoryRequestN <= 1'b1;
    #1 check("mem status", busCycleStatus, 3'h5);
    @(posedge ref_clk);
    #1 check("mem off", slaveMemoryAckN, 1);
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) dma(i[0], i[1], i[2], i[3:0]);
    // hardware reset counted in bus clocks, then in transmit clocks
    hw_reset(1'b1);
    hw_reset(1'b0);
    final_report();
  end
endmodule : test_sbi_bus_pins
